// [src/pcr_pkg.sv]
// Purpose: constants and carrier types for the port capability register bank
// Assumes: dword-aligned configuration offsets, 32-bit data
// Notes:   shared by pcr_regs and pcr_w1cs
package pcr_pkg;

   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [11:0] OFS_DEVCAP2 = 12'h0e4;
   localparam logic [11:0] OFS_DEVCTL2 = 12'h0e8;
   localparam logic [11:0] OFS_LNKCAP2 = 12'h0ec;
   localparam logic [11:0] OFS_LNKCTL2 = 12'h0f0;
   localparam logic [11:0] OFS_SLTCAP2 = 12'h0f4;
   localparam logic [11:0] OFS_SLTCTL2 = 12'h0f8;
   localparam logic [11:0] OFS_AERHDR  = 12'h100;
   localparam logic [11:0] OFS_UESTAT  = 12'h104;

   // ==========================================================
   // field positions and fixed values
   localparam int          DC2_LTR_BIT  = 11;
   localparam int          DC2_OBFF_LO  = 18;
   localparam int          DC2_OBFF_HI  = 19;
   localparam logic [1:0]  DC2_OBFF_SUP = 2'h1;
   localparam int          DCT_LTR_BIT  = 10;
   localparam int          DCT_OBFF_LO  = 13;
   localparam int          DCT_OBFF_HI  = 14;
   localparam int          LC2_TOP      = 12;
   localparam int          LS2_DEEMPH   = 16;
   localparam logic [3:0]  LC2_SPEED_RST = 4'h2;
   localparam logic [15:0] AER_CAP_ID   = 16'h0001;
   localparam logic [3:0]  AER_CAP_VER  = 4'h1;
   localparam logic [11:0] AER_NEXT     = 12'h140;
   localparam int          AER_VER_LO   = 16;
   localparam int          AER_NEXT_LO  = 20;
   localparam logic [31:0] UES_IMPL     = 32'h003f_f011;

   // ==========================================================
   // carrier types
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [11:0] addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } pcr_req_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
   } pcr_rsp_s;

   // one-cycle event pulses, named per status bit
   typedef struct packed {
      logic acs_violation;
      logic unsupported_req;
      logic ecrc_error;
      logic malformed_tlp;
      logic rx_overflow;
      logic unexpected_cpl;
      logic completer_abort;
      logic cpl_timeout;
      logic fc_protocol;
      logic poisoned_tlp;
      logic dl_protocol;
      logic training_error;
   } pcr_uerr_s;

   // second link control, bits 12:0 in place
   typedef struct packed {
      logic       compliance_deemph;
      logic       compliance_skip_ordered_sets;
      logic       modified_compliance;
      logic [2:0] transmit_margin;
      logic       select_deemph;
      logic       hardware_speed_change_disable;
      logic       enter_compliance;
      logic [3:0] target_speed;
   } pcr_lc2_s;

   typedef struct packed {
      logic [31:0] bits;
   } pcr_ues_s;

endpackage : pcr_pkg

// [src/pcr_w1cs.sv]
// Purpose: sticky write-one-to-clear status word
// Assumes: set and clear pulses on clk; rst_n is the power-on reset
// Notes:   a set in the clear cycle wins; only IMPL bits can ever be one
`timescale 1ns/100ps
`default_nettype none
module pcr_w1cs
   import pcr_pkg::*;
#(
   parameter int          W    = 32,
   parameter logic [31:0] IMPL = UES_IMPL
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [31:0] set_bits,
   input  wire logic [31:0] clr_bits,
   output var  logic [31:0] status
);

   if (W != 32) begin : g_bad_width
      $error("pcr_w1cs serves a 32-bit word only");
   end

   // ==========================================================
   // state
   pcr_ues_s st_reg;
   pcr_ues_s st_next;

   always_comb begin
      st_next      = st_reg;
      st_next.bits = ((st_reg.bits & ~clr_bits) | set_bits) & IMPL;
   end

   // not touched by link reset: sticky
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign status = st_reg.bits;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_set_wins_clr: assert property ((set_bits & IMPL) != 0
      |=> (status & $past(set_bits) & IMPL) == ($past(set_bits) & IMPL))
      else $error("status bit lost when set and clear met");
   a_rsvd_stays_zero: assert property ((status & ~IMPL) == 0)
      else $error("reserved status bit became one");
   a_hold_no_event: assert property ((set_bits == 0) && (clr_bits == 0)
      |=> $stable(status))
      else $error("status changed with no event or clear");

endmodule : pcr_w1cs
`default_nettype wire

// [src/pcr_regs.sv]
// Purpose: second-generation capability/control and error status bank
// Assumes: one configuration request port; events pulse on clk
// Notes:   rst_n clears all but target speed (2h) and select de-emphasis; link_rst_n spares sticky fields
//
// What this block does
// - second device capabilities bit 11 reads one, latency tolerance supported.
// - second device capabilities bits 19:18 read 01b, buffer flush/fill.
// - device control bit 10 and bits 14:13 writable, reset to zero.
// - error reporting header low sixteen bits read 0001h.
// - error reporting header bits 19:16 read version 1h.
// - error reporting header bits 31:20 read next pointer 140h.
// - status bit 0 latches training error, sticky, write one clears.
// - status bit 4 latches data link protocol error, sticky, write one clears.
// - status bit 12 latches poisoned packet received or generated.
// - status bit 13 latches flow control protocol error.
// - status bit 14 latches completion timeout.
// - status bit 15 latches completer abort.
// - status bit 16 latches unexpected completion.
// - status bit 17 latches receive buffer overflow.
// - status bit 18 latches malformed packet.
// - status bit 19 latches end-to-end CRC error.
// - status bit 20 latches unsupported request.
// - status bit 21 latches access control violation.
// - masked error sends no error message to the root complex.
`timescale 1ns/100ps
`default_nettype none
module pcr_regs
   import pcr_pkg::*;
#(
   parameter bit IS_UPSTREAM = 1'b1
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        link_rst_n,
   input  wire pcr_req_s    cfg_req,
   output var  pcr_rsp_s    cfg_rsp,
   input  wire pcr_uerr_s   uerr_event,
   input  wire logic [31:0] uerr_mask,
   output var  logic [31:0] uerr_status,
   output var  logic        err_msg_req,
   output var  logic        ltr_enable,
   output var  logic [1:0]  obff_enable,
   output var  pcr_lc2_s    link_ctl2
);

   localparam logic DEEMPH = ~IS_UPSTREAM;

   // ==========================================================
   // helpers
   function automatic logic [31:0] be_mask(input logic [3:0] be);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{be[i]}};
      end
      return m;
   endfunction : be_mask

   function automatic logic [31:0] wr_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
      logic [31:0] m;
      m = be_mask(be);
      return (old & ~m) | (wd & m);
   endfunction : wr_merge

   function automatic logic [31:0] ev_vec(input pcr_uerr_s e);
      logic [31:0] v;
      v     = '0;
      v[0]  = e.training_error;
      v[4]  = e.dl_protocol;
      v[12] = e.poisoned_tlp;
      v[13] = e.fc_protocol;
      v[14] = e.cpl_timeout;
      v[15] = e.completer_abort;
      v[16] = e.unexpected_cpl;
      v[17] = e.rx_overflow;
      v[18] = e.malformed_tlp;
      v[19] = e.ecrc_error;
      v[20] = e.unsupported_req;
      v[21] = e.acs_violation;
      return v;
   endfunction : ev_vec

   // ==========================================================
   // state
   typedef struct packed {
      pcr_rsp_s   rsp;
      logic       ltr_en;
      logic [1:0] obff_en;
      pcr_lc2_s   lc2;
      logic       msg;
   } pcr_state_s;

   pcr_state_s  st_reg;
   pcr_state_s  st_next;
   logic [31:0] ev_bits;
   logic [31:0] clr_bits;
   logic [31:0] rd_word;
   logic [31:0] wr_dc;
   logic [31:0] wr_lc;
   logic        do_wr;

   // ==========================================================
   // status word
   always_comb begin
      ev_bits = ev_vec(uerr_event);
   end

   assign do_wr = cfg_req.valid && cfg_req.write;

   always_comb begin
      clr_bits = '0;
      if (do_wr && cfg_req.addr == OFS_UESTAT) begin
         clr_bits = cfg_req.wdata & be_mask(cfg_req.be);
      end
   end

   pcr_w1cs #(
      .W    (32),
      .IMPL (UES_IMPL)
   ) u_ues (
      .clk      (clk),
      .rst_n    (rst_n),
      .set_bits (ev_bits),
      .clr_bits (clr_bits),
      .status   (uerr_status)
   );

   // ==========================================================
   // read decode
   always_comb begin
      rd_word = '0;
      unique case (cfg_req.addr)
         OFS_DEVCAP2: begin
            rd_word[DC2_LTR_BIT] = 1'b1;
            rd_word[DC2_OBFF_HI:DC2_OBFF_LO] = DC2_OBFF_SUP;
         end
         OFS_DEVCTL2: begin
            rd_word[DCT_LTR_BIT] = st_reg.ltr_en;
            rd_word[DCT_OBFF_HI:DCT_OBFF_LO] = st_reg.obff_en;
         end
         OFS_LNKCTL2: begin
            rd_word[LC2_TOP:0] = st_reg.lc2;
            rd_word[LS2_DEEMPH] = DEEMPH;
         end
         OFS_AERHDR: begin
            rd_word[AER_VER_LO-1:0] = AER_CAP_ID;
            rd_word[AER_NEXT_LO-1:AER_VER_LO] = AER_CAP_VER;
            rd_word[31:AER_NEXT_LO] = AER_NEXT;
         end
         OFS_UESTAT: begin
            rd_word = uerr_status;
         end
         default: begin
            rd_word = '0;
         end
      endcase
   end

   // ==========================================================
   // writes and answer
   always_comb begin
      wr_dc = wr_merge({17'h0_0000, st_reg.obff_en, 2'h0,
                        st_reg.ltr_en, 10'h000},
                       cfg_req.wdata, cfg_req.be);
      wr_lc = wr_merge({19'h0_0000, st_reg.lc2},
                       cfg_req.wdata, cfg_req.be);
   end

   always_comb begin
      st_next           = st_reg;
      st_next.rsp.ack   = cfg_req.valid;
      st_next.rsp.rdata = cfg_req.valid ? rd_word : '0;
      st_next.msg       = |(ev_bits & ~uerr_mask);
      if (do_wr && cfg_req.addr == OFS_DEVCTL2) begin
         st_next.ltr_en  = wr_dc[DCT_LTR_BIT];
         st_next.obff_en = wr_dc[DCT_OBFF_HI:DCT_OBFF_LO];
      end
      if (do_wr && cfg_req.addr == OFS_LNKCTL2) begin
         st_next.lc2 = wr_lc[LC2_TOP:0];
         st_next.lc2.select_deemph = DEEMPH;
      end
   end

   // link reset spares the sticky link control fields
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_reg                  <= '0;
         st_reg.lc2.target_speed <= LC2_SPEED_RST;
         st_reg.lc2.select_deemph <= DEEMPH;
      end else if (!link_rst_n) begin
         st_reg <= st_next;
         st_reg.rsp <= '0;
         st_reg.msg <= 1'b0;
         st_reg.ltr_en <= 1'b0;
         st_reg.obff_en <= 2'h0;
         st_reg.lc2.hardware_speed_change_disable <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign cfg_rsp     = st_reg.rsp;
   assign err_msg_req = st_reg.msg;
   assign ltr_enable  = st_reg.ltr_en;
   assign obff_enable = st_reg.obff_en;
   assign link_ctl2   = st_reg.lc2;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_rd(logic [11:0] a);
      link_rst_n && cfg_req.valid && !cfg_req.write && cfg_req.addr == a;
   endsequence

   a_cap_ltr_bit: assert property (
      s_rd(OFS_DEVCAP2) |=> cfg_rsp.ack && cfg_rsp.rdata[DC2_LTR_BIT])
      else $error("latency tolerance support bit not one");
   a_cap_obff_field: assert property (
      s_rd(OFS_DEVCAP2)
      |=> cfg_rsp.rdata[DC2_OBFF_HI:DC2_OBFF_LO] == DC2_OBFF_SUP)
      else $error("flush/fill support field wrong");
   a_ltr_en_write: assert property (
      link_rst_n && do_wr && cfg_req.addr == OFS_DEVCTL2 && cfg_req.be[1]
      |=> ltr_enable == $past(cfg_req.wdata[DCT_LTR_BIT])
          && obff_enable == $past(cfg_req.wdata[DCT_OBFF_HI:DCT_OBFF_LO]))
      else $error("device control write not taken");
   a_aer_cap_id: assert property (
      s_rd(OFS_AERHDR) |=> cfg_rsp.rdata[15:0] == AER_CAP_ID)
      else $error("extended capability id wrong");
   a_aer_cap_ver: assert property (
      s_rd(OFS_AERHDR) |=> cfg_rsp.rdata[19:16] == AER_CAP_VER)
      else $error("capability version wrong");
   a_aer_next_ptr: assert property (
      s_rd(OFS_AERHDR) |=> cfg_rsp.rdata[31:20] == AER_NEXT)
      else $error("next capability pointer wrong");
   a_train_err_latch: assert property (
      uerr_event.training_error |=> uerr_status[0] ##1 (uerr_status[0] || $past(clr_bits[0])))
      else $error("training error not latched");
   a_event_bits_latch: assert property (
      ev_bits != 0 |=> (uerr_status & $past(ev_bits)) == $past(ev_bits))
      else $error("error event not latched");
   a_ues_w1c_clear: assert property (
      do_wr && cfg_req.addr == OFS_UESTAT && cfg_req.be == 4'hf
      && cfg_req.wdata[21] && !uerr_event.acs_violation
      |=> !uerr_status[21])
      else $error("write one did not clear status");
   a_speed_sticky: assert property (
      !link_rst_n && !(do_wr && cfg_req.addr == OFS_LNKCTL2)
      |=> $stable(link_ctl2.target_speed) && $stable(link_ctl2.transmit_margin))
      else $error("sticky link control lost on link reset");
   a_deemph_const: assert property (
      link_ctl2.select_deemph == DEEMPH)
      else $error("selectable de-emphasis not fixed");
   a_rsvd_read_zero: assert property (
      s_rd(OFS_SLTCAP2) or s_rd(OFS_SLTCTL2) or s_rd(OFS_LNKCAP2)
      |=> cfg_rsp.rdata == '0)
      else $error("unimplemented register not zero");
   a_lc2_rsvd_zero: assert property (
      s_rd(OFS_LNKCTL2) |=> cfg_rsp.rdata[15:13] == 3'h0
                             && cfg_rsp.rdata[31:17] == '0)
      else $error("reserved link control bits not zero");
   a_masked_no_msg: assert property (
      link_rst_n && (ev_bits & ~uerr_mask) == 0 |=> !err_msg_req)
      else $error("message sent for masked error");
   a_unmasked_msg: assert property (
      link_rst_n && (ev_bits & ~uerr_mask) != 0 |=> err_msg_req ##1 !err_msg_req
                                   or err_msg_req)
      else $error("no message for unmasked error");
   a_ack_one_cycle: assert property (
      cfg_req.valid && link_rst_n |=> cfg_rsp.ack)
      else $error("request not answered next cycle");

   // answer and message framing
   a_ack_only_req: assert property (
      !cfg_req.valid |=> !cfg_rsp.ack)
      else $error("answer without a request");
   a_no_ack_link_rst: assert property (
      !link_rst_n |=> !cfg_rsp.ack && !err_msg_req)
      else $error("answer or message during link reset");
   a_rdata_idle_zero: assert property (
      !cfg_rsp.ack |-> cfg_rsp.rdata == '0)
      else $error("read data not zero without answer");
   a_msg_has_cause: assert property (
      err_msg_req |-> $past(ev_bits & ~uerr_mask) != 0)
      else $error("message with no unmasked event");

   // reserved and read-back bits
   a_cap_rsvd_zero: assert property (
      s_rd(OFS_DEVCAP2) |=> cfg_rsp.rdata[31:20] == '0
                             && cfg_rsp.rdata[17:12] == '0 && cfg_rsp.rdata[10:0] == '0)
      else $error("reserved capability bits not zero");
   a_dctl_rsvd_zero: assert property (
      s_rd(OFS_DEVCTL2) |=> cfg_rsp.rdata[31:15] == '0
                             && cfg_rsp.rdata[12:11] == '0 && cfg_rsp.rdata[9:0] == '0)
      else $error("reserved device control bits not zero");
   a_dctl_read_back: assert property (
      s_rd(OFS_DEVCTL2) |=> cfg_rsp.rdata[DCT_LTR_BIT] == ltr_enable
                             && cfg_rsp.rdata[DCT_OBFF_HI:DCT_OBFF_LO] == obff_enable)
      else $error("device control read differs from enables");
   a_ues_read: assert property (
      s_rd(OFS_UESTAT) |=> cfg_rsp.rdata == $past(uerr_status))
      else $error("status read differs from status word");
   a_lnk_stat_deemph: assert property (
      s_rd(OFS_LNKCTL2) |=> cfg_rsp.rdata[LS2_DEEMPH] == DEEMPH)
      else $error("current de-emphasis bit wrong");

   // control fields across writes and link reset
   pcr_lc2_s lc2_wd;
   assign lc2_wd = cfg_req.wdata[LC2_TOP:0];

   a_dctl_hold: assert property (
      link_rst_n && !(do_wr && cfg_req.addr == OFS_DEVCTL2)
      |=> $stable(ltr_enable) && $stable(obff_enable))
      else $error("device control changed with no write");
   a_link_rst_clear: assert property (
      !link_rst_n |=> !ltr_enable && obff_enable == 2'h0
                      && !link_ctl2.hardware_speed_change_disable)
      else $error("link reset left non-sticky fields set");
   a_lc2_write: assert property (
      do_wr && cfg_req.addr == OFS_LNKCTL2 && cfg_req.be == 4'hf
      |=> link_ctl2.target_speed == $past(lc2_wd.target_speed)
          && link_ctl2.transmit_margin == $past(lc2_wd.transmit_margin))
      else $error("link control write not taken");
   a_lc2_hold: assert property (
      !(do_wr && cfg_req.addr == OFS_LNKCTL2) |=> $stable(link_ctl2.target_speed)
      && $stable(link_ctl2.compliance_deemph) && $stable(link_ctl2.enter_compliance))
      else $error("link control changed with no write");

   c_status_clear: cover property (
      uerr_status[12] ##1 do_wr && cfg_req.addr == OFS_UESTAT ##1 !uerr_status[12]);
   c_set_and_clear: cover property (
      uerr_event.poisoned_tlp && do_wr && cfg_req.addr == OFS_UESTAT
      && cfg_req.wdata[12]);
   c_lc2_write: cover property (
      do_wr && cfg_req.addr == OFS_LNKCTL2 ##1 link_ctl2.enter_compliance);
   c_masked_event: cover property (
      (ev_bits & uerr_mask) != 0 ##1 !err_msg_req);
   c_link_rst_keep: cover property (
      !link_rst_n ##1 link_ctl2.transmit_margin != 3'h0);

endmodule : pcr_regs
`default_nettype wire

// [dv/pcr_rc_model.sv]
// Purpose: configuration requester standing in for the root complex
// Assumes: one request outstanding; answer one cycle after the taking edge
// Notes:   GAP idle cycles after each answer make a slow requester
`timescale 1ns/100ps
`default_nettype none
module pcr_rc_model
   import pcr_pkg::*;
#(
   parameter int GAP = 0
) (
   input  wire logic     clk,
   output var  pcr_req_s cfg_req,
   input  wire pcr_rsp_s cfg_rsp
);
   initial cfg_req = '0;

   // ==========================================================
   // one request, valid one cycle; released fields inverted
   task automatic access(input logic w, input logic [11:0] a, input logic [3:0] be,
                         input logic [31:0] wd, output logic [31:0] rd, output bit ok);
      ok = 1'b0;
      rd = '0;
      @(posedge clk);
      cfg_req <= '{1'b1, w, a, be, wd};
      @(posedge clk);
      cfg_req <= '{1'b0, ~w, ~a, ~be, ~wd};
      for (int i = 0; i < 4 && !ok; i++) begin
         #1;
         if (cfg_rsp.ack === 1'b1) begin
            rd = cfg_rsp.rdata;
            ok = 1'b1;
         end else begin
            @(posedge clk);
         end
      end
      repeat (GAP) @(posedge clk);
   endtask : access
endmodule : pcr_rc_model
`default_nettype wire

// [dv/test_pcr_regs.sv]
// Purpose: self-checking bench for the port capability register bank
// Assumes: upstream and downstream instances share one requester model
// Notes:   each scenario is a task of its own
`timescale 1ns/100ps
`default_nettype none
module test_pcr_regs
   import pcr_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        link_rst_n = 1'b1;
   pcr_req_s    cfg_req;
   pcr_rsp_s    cfg_rsp;
   pcr_uerr_s   uerr_event = '0;
   logic [31:0] uerr_mask = '0;
   logic [31:0] uerr_status;
   logic        err_msg_req;
   logic        ltr_enable;
   logic [1:0]  obff_enable;
   pcr_lc2_s    link_ctl2;
   pcr_rsp_s    cfg_rsp_dn;
   pcr_lc2_s    link_ctl2_dn;
   int          errors = 0;
   int          n_compared = 0;

   pcr_regs #(.IS_UPSTREAM(1'b1)) i_pcr_regs (
      .clk(clk), .rst_n(rst_n), .link_rst_n(link_rst_n), .cfg_req(cfg_req),
      .cfg_rsp(cfg_rsp), .uerr_event(uerr_event), .uerr_mask(uerr_mask),
      .uerr_status(uerr_status), .err_msg_req(err_msg_req), .ltr_enable(ltr_enable),
      .obff_enable(obff_enable), .link_ctl2(link_ctl2));
   pcr_rc_model #(.GAP(0)) i_pcr_rc_model (.clk(clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));
   pcr_regs #(.IS_UPSTREAM(1'b0)) i_pcr_regs_dn (
      .clk(clk), .rst_n(rst_n), .link_rst_n(link_rst_n), .cfg_req(cfg_req),
      .cfg_rsp(cfg_rsp_dn), .uerr_event(uerr_event), .uerr_mask(uerr_mask),
      .uerr_status(), .err_msg_req(), .ltr_enable(), .obff_enable(),
      .link_ctl2(link_ctl2_dn));

   always #20 clk = ~clk;

   // ==========================================================
   // common tasks
   task automatic stop_test;
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] be,
                      input logic [31:0] wd, output logic [31:0] rd);
      bit ok;
      i_pcr_rc_model.access(w, a, be, wd, rd, ok);
      if (!ok) begin
         errors++;
         stop_test();
      end
   endtask : acc

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] v;
      acc(1'b0, a, 4'hf, 32'h0000_0000, v);
      chk($sformatf("reg %h", a), v, exp);
   endtask : rd_chk

   task automatic wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] wd);
      logic [31:0] v;
      acc(1'b1, a, be, wd, v);
   endtask : wr

   task automatic rst_pulse(input bit por);
      @(posedge clk);
      if (por) rst_n <= 1'b0;
      else link_rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      link_rst_n <= 1'b1;
   endtask : rst_pulse

   // one event cycle, then the message pulse and its end
   task automatic pulse(input int k, input logic msg);
      @(posedge clk);
      uerr_event <= pcr_uerr_s'(12'h001 << k);
      @(posedge clk);
      uerr_event <= '0;
      #1;
      chk("msg", {31'h0, err_msg_req}, {31'h0, msg});
      @(posedge clk);
      #1;
      chk("msg end", {31'h0, err_msg_req}, 32'h0000_0000);
   endtask : pulse

   function automatic int pos(input int k);
      return (k == 0) ? 0 : (k == 1) ? 4 : k + 10;
   endfunction : pos

   // ==========================================================
   // scenarios
   task automatic t_reset_map;
      logic [11:0] a [11] = '{12'h0e4, 12'h0e8, 12'h0ec, 12'h0f0, 12'h0f4, 12'h0f8,
                              12'h100, 12'h104, 12'h0fc, 12'h200, 12'h101};
      logic [31:0] e [11] = '{32'h0004_0800, 0, 0, 32'h0000_0002, 0, 0,
                              32'h1401_0001, 0, 0, 0, 0};
      #1;
      chk("lc2 port", {19'h0, link_ctl2}, 32'h0000_0002);
      chk("dev ctl port", {29'h0, obff_enable, ltr_enable}, 32'h0000_0000);
      for (int i = 0; i < 11; i++) begin
         rd_chk(a[i], e[i]);
         if (a[i] != 12'h0e8 && a[i] != 12'h0f0 && a[i] != 12'h104) begin
            wr(a[i], 4'hf, 32'hffff_ffff);
            rd_chk(a[i], e[i]);
         end
      end
   endtask : t_reset_map

   task automatic t_dev_ctl;
      wr(12'h0e8, 4'hf, 32'hffff_ffff);
      chk("dev ctl port", {29'h0, obff_enable, ltr_enable}, 32'h0000_0007);
      rd_chk(12'h0e8, 32'h0000_6400);
      wr(12'h0e8, 4'h1, 32'h0000_0000);
      rd_chk(12'h0e8, 32'h0000_6400);
      wr(12'h0e8, 4'h2, 32'h0000_0000);
      rd_chk(12'h0e8, 32'h0000_0000);
      chk("dev ctl port", {29'h0, obff_enable, ltr_enable}, 32'h0000_0000);
   endtask : t_dev_ctl

   task automatic t_link_ctl;
      wr(12'h0e8, 4'h2, 32'h0000_0400);
      wr(12'h0f0, 4'hf, 32'hffff_ffff);
      rd_chk(12'h0f0, 32'h0000_1fbf);
      chk("lc2 port", {19'h0, link_ctl2}, 32'h0000_1fbf);
      rst_pulse(1'b0);
      rd_chk(12'h0f0, 32'h0000_1f9f);
      rd_chk(12'h0e8, 32'h0000_0000);
      rst_pulse(1'b1);
      rd_chk(12'h0f0, 32'h0000_0002);
   endtask : t_link_ctl

   task automatic t_status;
      logic [31:0] exp;
      exp = '0;
      for (int k = 0; k < 12; k++) begin
         pulse(k, 1'b1);
         exp[pos(k)] = 1'b1;
         chk("status", uerr_status, exp);
      end
      rst_pulse(1'b0);
      rd_chk(12'h104, 32'h003f_f011);
      wr(12'h104, 4'hf, 32'hffc0_0fee);
      rd_chk(12'h104, exp);
      for (int k = 0; k < 12; k++) begin
         wr(12'h104, 4'hf, 32'h0000_0001 << pos(k));
         exp[pos(k)] = 1'b0;
         rd_chk(12'h104, exp);
      end
   endtask : t_status

   task automatic t_mask;
      @(posedge clk);
      uerr_mask <= 32'h0000_4000;
      pulse(4, 1'b0);
      pulse(5, 1'b1);
      chk("masked status", uerr_status, 32'h0000_c000);
      @(posedge clk);
      uerr_mask <= 32'h0000_0000;
      wr(12'h104, 4'hf, 32'h0000_c000);
      rd_chk(12'h104, 32'h0000_0000);
   endtask : t_mask

   // clear of bit 12 in the same cycle as a new poisoned event
   task automatic t_set_wins;
      pulse(2, 1'b1);
      fork
         wr(12'h104, 4'hf, 32'h0000_1000);
         begin
            @(posedge clk);
            uerr_event <= pcr_uerr_s'(12'h004);
            @(posedge clk);
            uerr_event <= '0;
         end
      join
      rd_chk(12'h104, 32'h0000_1000);
      wr(12'h104, 4'hf, 32'h0000_1000);
      rd_chk(12'h104, 32'h0000_0000);
   endtask : t_set_wins

   // downstream port: de-emphasis bits read one
   task automatic t_downstream;
      logic [31:0] v;
      chk("dn lc2 port", {19'h0, link_ctl2_dn}, 32'h0000_0042);
      acc(1'b0, 12'h0f0, 4'hf, 32'h0000_0000, v);
      chk("dn reg 0f0", cfg_rsp_dn.rdata, 32'h0001_0042);
      wr(12'h0f0, 4'hf, 32'hffff_ffbf);
      acc(1'b0, 12'h0f0, 4'hf, 32'h0000_0000, v);
      chk("dn reg 0f0 wr", cfg_rsp_dn.rdata, 32'h0001_1fff);
      chk("up reg 0f0 wr", v, 32'h0000_1fbf);
   endtask : t_downstream

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_reset_map();
      t_dev_ctl();
      t_link_ctl();
      t_status();
      t_mask();
      t_set_wins();
      t_downstream();
      stop_test();
   end
endmodule : test_pcr_regs
`default_nettype wire
